// *** rtl/seo_pkg.sv ***
// constants, types and encodings for the serial eeprom opcode and status block
package seo_pkg;
	// opcodes
	localparam logic [7:0] OP_ARM = 8'h06;
	localparam logic [7:0] OP_CLEAR = 8'h04;
	localparam logic [7:0] OP_FETCH = 8'h05;
	localparam logic [7:0] OP_STORE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;
	localparam logic [7:0] OP_ID_READ = 8'h83;
	localparam logic [7:0] OP_ID_WRITE = 8'h82;
	// frame bit counts
	localparam logic [15:0] CNT_OPCODE = 16'h0008;
	localparam logic [15:0] CNT_STORE = 16'h0010;
	localparam logic [15:0] CNT_ADDR_END = 16'h0018;
	localparam logic [15:0] CNT_WRITE_MIN = 16'h0020;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;
	// status byte field positions
	localparam int unsigned ST_BUSY = 0;
	localparam int unsigned ST_WEL = 1;
	localparam int unsigned ST_PLO = 2;
	localparam int unsigned ST_PHI = 3;
	localparam int unsigned ST_LOCK = 7;
	// address
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned ADDR_SEL_BIT = 10;
	localparam logic [12:0] PROT_QUARTER_BASE = 13'h1800;
	localparam logic [12:0] PROT_HALF_BASE = 13'h1000;
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_QUARTER = 2'h1;
	localparam logic [1:0] PROT_HALF = 2'h2;
	// values after reset
	localparam logic [1:0] RST_PROT = 2'h0;
	localparam logic RST_LOCK = 1'h0;
	localparam logic RST_ID_LOCK = 1'h0;
	localparam logic [2:0] OUT_IDX_MSB = 3'h7;
	// self-timed cycle length in core clocks, plain default
	localparam int unsigned WRITE_CYCLES_DEF = 1000;

	typedef enum logic [2:0] {
		S_IDLE, S_OPCODE, S_ADDR, S_DATA, S_STATOUT, S_WAIT, S_READ, S_IGNORE
	} seo_state_t;

	typedef enum logic [2:0] {
		CM_NONE, CM_STATUS, CM_ARRAY, CM_ID_WRITE, CM_ID_LOCK
	} seo_cycle_t;

	typedef struct packed {
		logic rd;
		logic wr;
		logic idPage;
		logic [12:0] addr;
	} seo_mem_req_t;
endpackage : seo_pkg

// *** rtl/seo_sync.sv ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module seo_sync #(
	parameter logic RST_VAL = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// level in and out
	input wire logic din,
	output logic dout
);
	logic meta_r;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_r <= RST_VAL;
			dout <= RST_VAL;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : seo_sync
`default_nettype wire

// *** rtl/seo_wcycle.sv ***
// self-timed write cycle timer
`timescale 1ns/1ps
`default_nettype none
module seo_wcycle #(
	parameter int unsigned CYCLES = 1000
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// control
	input wire logic start,
	output logic busy,
	output logic done
);
	localparam int unsigned CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
	logic [CW-1:0] cnt_r;
	logic busy_r;
	wire logic atEnd = busy_r && (cnt_r == LAST);

	assign busy = busy_r;
	assign done = atEnd;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
		end else if (atEnd) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
		end else if (busy_r) begin
			cnt_r <= cnt_r + CW'(1);
		end else if (start) begin
			busy_r <= 1'b1;
			cnt_r <= '0;
		end
	end
endmodule : seo_wcycle
`default_nettype wire

// *** rtl/seo_opcode_status.sv ***
// opcode decoder and status byte of a serial eeprom slave
// What this block does
// [R1] opcodes are eight bits: arm 06h, clear 04h, fetch 05h
// [R2] store 01h, read 03h, write 02h
// [R3] unknown opcode: ignore everything until next chip select assertion
// [R4] 83h with A10 low starts identification page read
// [R5] 82h with A10 low writes identification page
// [R6] 83h with A10 high returns identification lock status
// [R7] 82h with A10 high locks identification page permanently
// [R8] only address bits 12..0 select a location
// [R9] arm command alone sets the write enable latch before writes
// [R10] arm acts only once chip select rises
// [R11] clear acts once chip select rises, clearing the latch
// [R12] latch cleared at reset, by clear, and at write or store completion
// [R13] status fetch accepted anytime, status repeats while selected
// [R14] master should poll busy before new instructions during a cycle
// [R15] busy reads 1 during write or store cycle, else 0
// [R16] status shows latch; latch clear rejects writes and stores
// [R17] two protect bits, written by store, block writes to region
// [R18] protect bits change only outside hardware lock mode
// [R19] lock bit set and protect pin low gives hardware lock mode
// [R20] protect code 01 upper quarter, 10 upper half, 11 whole array
// [R21] master raises chip select before the edge after last bit
// [R22] read while busy is not accepted
// [R23] cycle starts at chip select rise, busy clears at end
// [R24] arm or clear need exactly eight clocks before chip select rises
`timescale 1ns/1ps
`default_nettype none
module seo_opcode_status import seo_pkg::*; #(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF,
	parameter logic HAS_ID_PAGE = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial pins
	input wire logic sclk,
	input wire logic csN,
	input wire logic mosi,
	input wire logic wpN,
	output logic misoD,
	output logic misoOe,
	// status and memory side
	output logic [7:0] statusByte,
	output logic busy,
	output logic idLocked,
	output seo_mem_req_t memReq
);
	logic sclkS;
	logic csnS;
	logic mosiS;
	logic wpnS;
	logic sclkPrev_r;
	logic csnPrev_r;
	seo_state_t state_r;
	seo_state_t state_nxt;
	logic [15:0] bitCnt_r;
	logic [7:0] shiftIn_r;
	logic [7:0] opcode_r;
	logic [15:0] addr_r;
	logic wel_r;
	logic [1:0] prot_r;
	logic lock_r;
	logic idLock_r;
	logic armed_r;
	logic lockSel_r;
	logic lockSel_nxt;
	logic [2:0] outIdx_r;
	logic misoR;
	seo_mem_req_t memReq_r;
	seo_mem_req_t memReq_nxt;
	seo_cycle_t pendKind_r;
	logic [7:0] pendData_r;
	logic cycleDone;

	// pins are asynchronous to core_clk
	seo_sync #(.RST_VAL(1'b0)) uSyncClk (.core_clk(core_clk), .rst(rst), .din(sclk), .dout(sclkS));
	seo_sync #(.RST_VAL(1'b1)) uSyncCs (.core_clk(core_clk), .rst(rst), .din(csN), .dout(csnS));
	seo_sync #(.RST_VAL(1'b0)) uSyncDi (.core_clk(core_clk), .rst(rst), .din(mosi), .dout(mosiS));
	seo_sync #(.RST_VAL(1'b1)) uSyncWp (.core_clk(core_clk), .rst(rst), .din(wpN), .dout(wpnS));

	// edges and decode
	wire logic sclkRise = sclkS & ~sclkPrev_r;
	wire logic sclkFall = ~sclkS & sclkPrev_r;
	wire logic csFall = ~csnS & csnPrev_r;
	wire logic csRise = csnS & ~csnPrev_r;
	wire logic [15:0] cntInc = (bitCnt_r == CNT_MAX) ? bitCnt_r : bitCnt_r + 16'h0001;
	wire logic [7:0] newByte = {shiftIn_r[6:0], mosiS};
	wire logic [15:0] addrFull = {addr_r[14:0], mosiS};
	wire logic [12:0] memAddr = addr_r[ADDR_W-1:0]; // [R8]
	wire logic hwLock = lock_r & ~wpnS; // [R19]
	wire logic byteEnd = (bitCnt_r >= CNT_WRITE_MIN) && (bitCnt_r[2:0] == 3'h0);
	wire logic idSel = addr_r[ADDR_SEL_BIT];

	// write-blocked range from the protect code
	wire logic protHit = (prot_r == PROT_NONE) ? 1'b0 :
		(prot_r == PROT_QUARTER) ? (memAddr >= PROT_QUARTER_BASE) :
		(prot_r == PROT_HALF) ? (memAddr >= PROT_HALF_BASE) : 1'b1; // [R17] [R20]

	// commit checks at chip select rise
	wire logic armOk = (state_r == S_WAIT) && (opcode_r == OP_ARM) &&
		(bitCnt_r == CNT_OPCODE); // [R10] [R24]
	wire logic clearOk = (state_r == S_WAIT) && (opcode_r == OP_CLEAR) &&
		(bitCnt_r == CNT_OPCODE); // [R11] [R24]
	wire logic inData = (state_r == S_DATA);
	wire logic canWrite = wel_r && !busy; // [R16]
	wire logic storeOk = inData && (opcode_r == OP_STORE) && (bitCnt_r == CNT_STORE) &&
		canWrite && !hwLock; // [R18] [R19]
	wire logic arrOk = inData && (opcode_r == OP_WRITE) && byteEnd && canWrite && !protHit; // [R17]
	wire logic idWrOk = inData && (opcode_r == OP_ID_WRITE) && byteEnd && canWrite &&
		!idSel && !idLock_r; // [R5]
	wire logic idLkOk = inData && (opcode_r == OP_ID_WRITE) && byteEnd && canWrite &&
		idSel && !idLock_r; // [R7]
	wire logic startCycle = csRise && (storeOk || arrOk || idWrOk || idLkOk); // [R23]
	wire seo_cycle_t startKind = storeOk ? CM_STATUS : arrOk ? CM_ARRAY :
		idWrOk ? CM_ID_WRITE : idLkOk ? CM_ID_LOCK : CM_NONE;

	// status byte, upper unused bits read zero
	assign statusByte = {lock_r, 3'h0, prot_r[1], prot_r[0], wel_r, busy}; // [R15] [R16]
	wire logic [7:0] outByte = lockSel_r ? {7'h00, idLock_r} : statusByte; // [R6]

	assign misoD = misoR;
	assign misoOe = (state_r == S_STATOUT);
	assign idLocked = idLock_r;
	assign memReq = memReq_r;

	seo_wcycle #(.CYCLES(WRITE_CYCLES)) uCycle (
		.core_clk(core_clk),
		.rst(rst),
		.start(startCycle),
		.busy(busy),
		.done(cycleDone)
	); // [R15] [R23]

	// opcode decode after the eighth bit
	function automatic seo_state_t decodeOp(input logic [7:0] op, input logic bsy, input logic idv);
		seo_state_t s;
		s = S_IGNORE; // [R3]
		if ((op == OP_ARM) || (op == OP_CLEAR)) begin
			s = S_WAIT; // [R1]
		end else if (op == OP_FETCH) begin
			s = S_STATOUT; // [R13]
		end else if (op == OP_STORE) begin
			s = S_DATA; // [R2]
		end else if (op == OP_READ) begin
			s = bsy ? S_IGNORE : S_ADDR; // [R22]
		end else if (op == OP_WRITE) begin
			s = S_ADDR; // [R2]
		end else if (idv && (op == OP_ID_READ)) begin
			// id page sits in the array, so a running cycle blocks it too
			s = bsy ? S_IGNORE : S_ADDR; // [R4] [R22]
		end else if (idv && (op == OP_ID_WRITE)) begin
			s = S_ADDR; // [R5]
		end
		return s;
	endfunction : decodeOp

	// frame sequencing
	always_comb begin
		state_nxt = state_r;
		lockSel_nxt = lockSel_r;
		memReq_nxt = '0;
		if (csRise) begin
			state_nxt = S_IDLE;
		end else if (csFall && armed_r && (state_r == S_IDLE)) begin
			state_nxt = S_OPCODE;
			lockSel_nxt = 1'b0;
		end else if (sclkRise) begin
			unique case (state_r)
				S_OPCODE: begin
					if (cntInc == CNT_OPCODE) begin
						state_nxt = decodeOp(newByte, busy, HAS_ID_PAGE);
					end
				end
				S_ADDR: begin
					if (cntInc == CNT_ADDR_END) begin
						memReq_nxt.addr = addrFull[ADDR_W-1:0]; // [R8]
						if (opcode_r == OP_READ) begin
							memReq_nxt.rd = 1'b1;
							state_nxt = S_READ;
						end else if ((opcode_r == OP_ID_READ) && !addrFull[ADDR_SEL_BIT]) begin
							memReq_nxt.rd = 1'b1; // [R4]
							memReq_nxt.idPage = 1'b1;
							state_nxt = S_READ;
						end else if (opcode_r == OP_ID_READ) begin
							lockSel_nxt = 1'b1; // [R6]
							state_nxt = S_STATOUT;
						end else begin
							state_nxt = S_DATA;
						end
					end
				end
				S_IDLE, S_DATA, S_STATOUT, S_WAIT, S_READ, S_IGNORE: begin
					state_nxt = state_r;
				end
			endcase
		end
		if (startCycle && (arrOk || idWrOk)) begin
			memReq_nxt.wr = 1'b1;
			memReq_nxt.idPage = idWrOk;
			memReq_nxt.addr = memAddr;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sclkPrev_r <= 1'b0;
			csnPrev_r <= 1'b1;
			state_r <= S_IDLE;
			lockSel_r <= 1'b0;
			memReq_r <= '0;
			armed_r <= 1'b0;
		end else begin
			sclkPrev_r <= sclkS;
			csnPrev_r <= csnS;
			state_r <= state_nxt;
			lockSel_r <= lockSel_nxt;
			memReq_r <= memReq_nxt;
			// selection needs chip select seen high after reset first
			if (csnS) begin
				armed_r <= 1'b1;
			end
		end
	end

	// input shifting and bit count
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bitCnt_r <= '0;
			shiftIn_r <= '0;
			opcode_r <= '0;
			addr_r <= '0;
		end else if (state_nxt == S_OPCODE && state_r == S_IDLE) begin
			bitCnt_r <= '0;
		end else if (sclkRise && (state_r != S_IDLE) && (state_r != S_IGNORE)) begin
			bitCnt_r <= cntInc;
			shiftIn_r <= newByte;
			if ((state_r == S_OPCODE) && (cntInc == CNT_OPCODE)) begin
				opcode_r <= newByte;
			end
			if (state_r == S_ADDR) begin
				addr_r <= addrFull;
			end
		end
	end

	// serial output, msb first, each bit read from the live byte
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			outIdx_r <= OUT_IDX_MSB;
			misoR <= 1'b0;
		end else if (state_r != S_STATOUT) begin
			outIdx_r <= OUT_IDX_MSB;
		end else if (sclkFall) begin
			misoR <= outByte[outIdx_r]; // [R13]
			outIdx_r <= outIdx_r - 3'h1;
		end
	end

	// write enable latch; a fresh arm wins over the completion clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wel_r <= 1'b0; // [R12]
		end else if (csRise && armOk) begin
			wel_r <= 1'b1; // [R9]
		end else if (csRise && clearOk) begin
			wel_r <= 1'b0; // [R11]
		end else if (cycleDone && (pendKind_r != CM_NONE)) begin
			wel_r <= 1'b0; // [R12]
		end
	end

	// pending cycle and non-volatile bits, updated at cycle end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pendKind_r <= CM_NONE;
			pendData_r <= '0;
			prot_r <= RST_PROT;
			lock_r <= RST_LOCK;
			idLock_r <= RST_ID_LOCK;
		end else if (startCycle) begin
			pendKind_r <= startKind;
			pendData_r <= shiftIn_r;
		end else if (cycleDone) begin
			pendKind_r <= CM_NONE;
			if (pendKind_r == CM_STATUS) begin
				prot_r <= {pendData_r[ST_PHI], pendData_r[ST_PLO]}; // [R17] [R18]
				lock_r <= pendData_r[ST_LOCK];
			end
			if (pendKind_r == CM_ID_LOCK) begin
				idLock_r <= 1'b1; // [R7]
			end
		end
	end
endmodule : seo_opcode_status
`default_nettype wire

// *** test/seo_opcode_status_assertions.sv ***
// assertion checker for the opcode and status block
`timescale 1ns/1ps
`default_nettype none
module seo_opcode_status_chk import seo_pkg::*; #(
	parameter int unsigned WRITE_CYCLES = WRITE_CYCLES_DEF
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// watched pins and outputs
	input wire logic csN,
	input wire logic misoOe,
	input wire logic [7:0] statusByte,
	input wire logic busy,
	input wire seo_mem_req_t memReq
);
	logic [15:0] busyCnt_r;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// counts busy clocks so the cycle length can be judged at its end
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busyCnt_r <= 16'h0000;
		end else begin
			busyCnt_r <= busy ? busyCnt_r + 16'h0001 : 16'h0000;
		end
	end
	a_busy_mirror: assert property (statusByte[ST_BUSY] == busy)
		else $error("busy bit differs from busy");
	a_busy_length: assert property ($fell(busy) |-> busyCnt_r == 16'(WRITE_CYCLES))
		else $error("write cycle length wrong");
	a_wr_starts_cycle: assert property (memReq.wr |-> busy && !$past(busy) && statusByte[ST_WEL])
		else $error("write request without latch or not starting cycle");
	a_rd_not_busy: assert property (memReq.rd |-> !busy)
		else $error("read accepted while busy");
	a_wel_on_deselect: assert property ($rose(statusByte[ST_WEL]) |-> $past(csN))
		else $error("latch set while selected");
	a_status_at_end: assert property ($changed(statusByte[7:2]) |-> $fell(busy))
		else $error("protect bits changed outside cycle end");
	a_oe_deselected: assert property (csN [*6] |-> !misoOe)
		else $error("output enabled while deselected");
	a_wr_range: assert property (memReq.wr && !memReq.idPage |->
		statusByte[3:2] == PROT_NONE
		|| (statusByte[3:2] == PROT_QUARTER && memReq.addr < PROT_QUARTER_BASE)
		|| (statusByte[3:2] == PROT_HALF && memReq.addr < PROT_HALF_BASE))
		else $error("write into protected range");
endmodule : seo_opcode_status_chk
bind seo_opcode_status seo_opcode_status_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk_u (
	.core_clk(core_clk), .rst(rst), .csN(csN), .misoOe(misoOe), .statusByte(statusByte),
	.busy(busy), .memReq(memReq));
`default_nettype wire

// *** test/seo_spi_master.sv ***
// spi bus master model, mode 0, driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module seo_spi_master (
	// clock
	input wire logic core_clk,
	// serial pins
	output logic sclk,
	output logic csN,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		mosi = 1'b0;
	end
	// six clocks a phase, above the two the synchroniser needs
	task automatic half();
		repeat (6) @(negedge core_clk);
	endtask : half
	// n bits msb first; rx keeps the last 8 bits seen on miso
	task automatic frame(input logic [39:0] d, input int n, output logic [7:0] rx);
		rx = 8'h00;
		csN = 1'b0;
		half();
		for (int i = n - 1; i >= 0; i--) begin
			mosi = d[i];
			half();
			sclk = 1'b1;
			rx = {rx[6:0], miso};
			half();
			sclk = 1'b0;
		end
		half();
		csN = 1'b1;
		mosi = ~mosi;
		half();
	endtask : frame
endmodule : seo_spi_master
`default_nettype wire

// *** test/test_spi_eeprom_opcode_status.sv ***
// self-checking bench for the opcode and status block
`timescale 1ns/1ps
`default_nettype none
module test_spi_eeprom_opcode_status;
	import seo_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic wpN = 1'b1;
	wire logic sclk, csN, mosi, miso;
	logic misoD, misoOe, busy, idLocked;
	logic [7:0] statusByte, rx;
	seo_mem_req_t memReq, lastReq;
	int n_errors = 0;
	int n_compared = 0;
	int nWr = 0;
	int nRd = 0;
	always #2.5 core_clk = ~core_clk;
	// released line shows inverted data, never a stale value
	assign miso = misoOe ? misoD : ~mosi;
	always @(posedge core_clk) begin
		if (memReq.rd === 1'b1 || memReq.wr === 1'b1) begin
			lastReq <= memReq;
		end
		nWr <= nWr + int'(memReq.wr === 1'b1);
		nRd <= nRd + int'(memReq.rd === 1'b1);
	end
	seo_opcode_status #(.WRITE_CYCLES(400), .HAS_ID_PAGE(1'b1)) dut_u (.core_clk(core_clk),
		.rst(rst), .sclk(sclk), .csN(csN), .mosi(mosi), .wpN(wpN), .misoD(misoD),
		.misoOe(misoOe), .statusByte(statusByte), .busy(busy), .idLocked(idLocked),
		.memReq(memReq));
	seo_spi_master m_u (.core_clk(core_clk), .sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask : check
	task automatic give_verdict();
		$display("mismatches %0d, comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : give_verdict
	task automatic send(input logic [39:0] d, input int n);
		m_u.frame(d, n, rx);
	endtask : send
	task automatic arm();
		send(40'(OP_ARM), 8);
	endtask : arm
	task automatic fetch(input logic [7:0] e);
		send(40'({OP_FETCH, 16'h0000}), 24);
		check("status", 16'(e), 16'(rx));
	endtask : fetch
	task automatic store(input logic [7:0] v);
		arm();
		send(40'({OP_STORE, v}), 16);
	endtask : store
	// polls busy like a careful master; a stuck cycle ends the run
	task automatic idle();
		for (int i = 0; i < 1000 && busy !== 1'b0; i++) begin
			@(negedge core_clk);
		end
		if (busy !== 1'b0) begin
			n_errors++;
			give_verdict();
		end
	endtask : idle
	initial begin
		repeat (5) @(negedge core_clk);
		rst = 1'b0;
		repeat (4) @(negedge core_clk);
		check("reset", 16'h0000, 16'({misoOe, busy, idLocked, statusByte}));
		fetch(8'h00);
		send(40'h03, 7);
		fetch(8'h00);
		send(40'({OP_ARM, 1'b0}), 9);
		fetch(8'h00);
		arm();
		fetch(8'h02);
		send(40'(OP_CLEAR), 8);
		fetch(8'h00);
		send(40'({OP_STORE, 8'h8C}), 16);
		check("store no latch", 16'h0000, 16'(statusByte));
		store(8'h8C);
		check("store busy", 16'h0003, 16'(statusByte));
		fetch(8'h03);
		idle();
		check("stored", 16'h008C, 16'(statusByte));
		arm();
		send(40'({OP_WRITE, 16'h0000, 8'hAA}), 32);
		check("write all protected", 16'h0000, 16'(nWr));
		wpN = 1'b0;
		store(8'h04);
		check("hw lock", 16'h008E, 16'(statusByte));
		wpN = 1'b1;
		store(8'h04);
		idle();
		check("unlocked store", 16'h0004, 16'(statusByte));
		arm();
		send(40'({OP_WRITE, 16'hE7FF, 8'h5A}), 32);
		check("write req", 16'h47FF, lastReq);
		send(40'({OP_READ, 16'h0000}), 24);
		check("read busy", 16'h0000, 16'(nRd));
		idle();
		check("latch after write", 16'h0004, 16'(statusByte));
		arm();
		send(40'({OP_WRITE, 16'h1800, 8'h5A}), 32);
		check("quarter protect", 16'h0001, 16'(nWr));
		send(40'({OP_READ, 16'hFABC, 8'h00}), 32);
		check("read req", 16'h9ABC, lastReq);
		send(40'({8'hFF, OP_READ, 16'h0000}), 32);
		check("bad opcode", 16'h0001, 16'(nRd));
		send(40'({OP_ID_READ, 16'hFBFF, 8'h00}), 32);
		check("id read", 16'h0005, 16'(lastReq[15:13]));
		send(40'({OP_ID_READ, 16'h0400, 8'h00}), 32);
		check("lock status", 16'h0002, 16'(nRd));
		check("lock status byte", 16'h0000, 16'(rx));
		arm();
		send(40'({OP_ID_WRITE, 16'h0000, 8'h55}), 32);
		check("id write", 16'h0003, 16'(lastReq[15:13]));
		idle();
		arm();
		send(40'({OP_ID_WRITE, 16'h0400, 8'h00}), 32);
		idle();
		check("id locked", 16'h0001, 16'(idLocked));
		send(40'({OP_ID_READ, 16'h0400, 8'h00}), 32);
		check("lock status set", 16'h0001, 16'(rx));
		arm();
		send(40'({OP_ID_WRITE, 16'h0000, 8'h55}), 32);
		check("id write locked", 16'h0000, 16'(busy));
		give_verdict();
	end
endmodule : test_spi_eeprom_opcode_status
`default_nettype wire
